// file: rtl/low_power_mode_controller.sv
`timescale 1ns/100ps
module low_power_mode_controller import lpm_pkg::*; #(
    parameter int unsigned WAKE_BASE = WAKE_BASE_DEFAULT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire axil_req_t axi_i,
    output axil_rsp_t axi_o,
    // cpu and interrupt controller
    input wire logic sleep_exec,
    input wire logic int_pending,
    input wire logic int_disabled,
    input wire logic nonnmi_masked,
    input wire logic nmi_edge_select,
    input wire logic [2:0] irq_enable,
    input wire logic [2:0] irq_cpu_masked,
    input wire logic [2:0] irq_xfer_source,
    input wire logic higher_prio_pending,
    input wire logic dma_active,
    input wire logic xfer_active,
    input wire logic bus_cycle_end,
    // pins
    input wire logic nmi_pin,
    input wire logic [2:0] irq_pin_n,
    input wire logic reset_pin_n,
    input wire logic hw_standby_pin_n,
    // power control
    output logic cpu_halt,
    output logic cpu_reset_hold,
    output logic osc_enable,
    output logic clock_supply,
    output logic hw_standby_mode,
    output logic int_exc_start,
    output logic reset_exc_start,
    output logic bus_oe_n,
    // peripheral control
    output logic [15:0] periph_run,
    output logic [15:0] periph_access_block,
    output logic [15:0] periph_state_clear
);
    typedef struct packed {
        mode_t mode;
        logic [15:0] stop;
        logic [15:0] stop_eff;
        logic standby_select;
        logic [2:0] wsel;
        logic ohe;
        logic rsv0;
        logic nmi_prev;
        logic int_go;
        logic res_go;
        logic aw_got;
        logic w_got;
        logic [AXI_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ctl_t;
    ctl_t q, d;
    logic nmi_s;
    logic [2:0] irq_n_s;
    logic res_s;
    logic hw_s;
    logic wake_done;
    logic nmi_ev;
    logic [2:0] irq_ok;
    logic irq_wake;
    logic sleep_wake;
    logic awready;
    logic wready;
    logic arready;
    logic wr_fire;
    logic wr_stop;
    logic init_now;
    logic clk_on;
    logic off_like;
    // every pin resets to its idle high level, so no false nmi edge
    pin_sync #(
        .WIDTH(6),
        .RESET_VAL(6'h3F)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({nmi_pin, irq_pin_n, reset_pin_n, hw_standby_pin_n}),
        .pin_sync_out({nmi_s, irq_n_s, res_s, hw_s})
    );
    wake_counter #(
        .WAKE_BASE(WAKE_BASE)
    ) u_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(q.mode == MODE_OSC),
        .sel(q.wsel),
        .done(wake_done)
    );
    // nmi edge polarity follows the cpu's own edge select
    assign nmi_ev = nmi_edge_select ? (nmi_s && !q.nmi_prev)
                                    : (!nmi_s && q.nmi_prev);
    assign irq_ok = ~irq_n_s & irq_enable & ~irq_cpu_masked & ~irq_xfer_source;
    assign irq_wake = (|irq_ok) && !higher_prio_pending;
    assign sleep_wake = nmi_ev
        || (int_pending && !int_disabled && !nonnmi_masked);
    assign awready = !q.aw_got && !q.bvalid;
    assign wready = !q.w_got && !q.bvalid;
    assign arready = !q.rvalid;
    assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
    assign wr_stop = wr_fire && (q.awaddr == ADDR_MOD_STOP);
    // reset pin and hardware standby both reload the registers
    assign init_now = (q.mode == MODE_RES) || (q.mode == MODE_HW);
    assign clk_on = (q.mode == MODE_RUN) || (q.mode == MODE_SLEEP);
    assign off_like = !clk_on;

    always_comb begin
        d = q;
        d.int_go = 1'h0;
        d.res_go = 1'h0;
        d.nmi_prev = nmi_s;
        if (axi_i.awvalid && awready) begin
            d.aw_got = 1'h1;
            d.awaddr = axi_i.awaddr;
        end
        if (axi_i.wvalid && wready) begin
            d.w_got = 1'h1;
            d.wdata = axi_i.wdata;
            d.wstrb = axi_i.wstrb;
        end
        if (q.bvalid && axi_i.bready) begin
            d.bvalid = 1'h0;
        end
        if (wr_fire) begin
            d.aw_got = 1'h0;
            d.w_got = 1'h0;
            d.bvalid = 1'h1;
            d.bresp = RESP_SLVERR;
            if (q.awaddr == ADDR_HW_STANDBY_PIN_CTRL) begin
                d.bresp = RESP_OKAY;
                if (q.wstrb[0]) begin
                    d.standby_select = q.wdata[STANDBY_SELECT_BIT];
                    d.wsel = q.wdata[WSEL_MSB:WSEL_LSB];
                    d.ohe = q.wdata[OHE_BIT];
                    d.rsv0 = q.wdata[RSV0_BIT];
                end
            end else if (q.awaddr == ADDR_MOD_STOP) begin
                d.bresp = RESP_OKAY;
                // spare bits store but gate nothing
                if (q.wstrb[0]) begin
                    d.stop[7:0] = q.wdata[7:0];
                end
                if (q.wstrb[1]) begin
                    d.stop[15:8] = q.wdata[15:8];
                    // a busy master cannot be stopped under it
                    d.stop[STOP_DMA_BIT] = q.wdata[STOP_DMA_BIT]
                        && (q.stop[STOP_DMA_BIT] || !dma_active);
                    d.stop[STOP_XFER_BIT] = q.wdata[STOP_XFER_BIT]
                        && (q.stop[STOP_XFER_BIT] || !xfer_active);
                end
            end else if (q.awaddr == ADDR_STATUS) begin
                d.bresp = RESP_OKAY;
            end
        end
        if (q.rvalid && axi_i.rready) begin
            d.rvalid = 1'h0;
        end
        if (axi_i.arvalid && arready) begin
            d.rvalid = 1'h1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            case (axi_i.araddr)
                ADDR_HW_STANDBY_PIN_CTRL: begin
                    d.rdata[STANDBY_SELECT_BIT] = q.standby_select;
                    d.rdata[WSEL_MSB:WSEL_LSB] = q.wsel;
                    d.rdata[OHE_BIT] = q.ohe;
                    d.rdata[RSV0_BIT] = q.rsv0;
                end
                ADDR_MOD_STOP: begin
                    d.rdata[15:0] = q.stop;
                end
                ADDR_STATUS: begin
                    d.rdata[STAT_SLEEP_BIT] = (q.mode == MODE_SLEEP);
                    d.rdata[STAT_HW_STANDBY_PIN_BIT] = (q.mode == MODE_HW_STANDBY_PIN);
                    d.rdata[STAT_OSC_BIT] = (q.mode == MODE_OSC);
                    d.rdata[STAT_EFF_LSB +: 16] = q.stop_eff;
                end
                default: begin
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
        // stop writes only take hold between bus cycles
        if (bus_cycle_end) begin
            d.stop_eff = q.stop;
        end
        case (q.mode)
            MODE_RUN: begin
                if (sleep_exec) begin
                    d.mode = q.standby_select ? MODE_HW_STANDBY_PIN : MODE_SLEEP;
                end
            end
            MODE_SLEEP: begin
                if (sleep_wake) begin
                    d.mode = MODE_RUN;
                    d.int_go = 1'h1;
                end
            end
            MODE_HW_STANDBY_PIN: begin
                if (nmi_ev || irq_wake) begin
                    d.mode = MODE_OSC;
                end
            end
            MODE_OSC: begin
                if (wake_done) begin
                    d.mode = MODE_RUN;
                    d.int_go = 1'h1;
                end
            end
            MODE_RES: begin
                if (res_s) begin
                    d.mode = MODE_RUN;
                    d.res_go = 1'h1;
                end
            end
            MODE_HW: begin
                if (hw_s) begin
                    d.mode = MODE_RES;
                end
            end
            default: begin
                d.mode = MODE_RUN;
            end
        endcase
        // clocks come back at once on the reset pin
        if (!res_s && q.mode != MODE_HW) begin
            d.mode = MODE_RES;
            d.int_go = 1'h0;
        end
        if (!hw_s) begin
            d.mode = MODE_HW;
            d.int_go = 1'h0;
            d.res_go = 1'h0;
        end
        if (init_now) begin
            d.stop = STOP_RESET;
            d.stop_eff = STOP_RESET;
            d.standby_select = STANDBY_SELECT_RESET;
            d.wsel = WSEL_RESET;
            d.ohe = OHE_RESET;
            d.rsv0 = RSV0_RESET;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.mode <= MODE_RUN;
            q.stop <= STOP_RESET;
            q.stop_eff <= STOP_RESET;
            q.standby_select <= STANDBY_SELECT_RESET;
            q.wsel <= WSEL_RESET;
            q.ohe <= OHE_RESET;
            q.rsv0 <= RSV0_RESET;
            q.nmi_prev <= 1'h1;
        end else begin
            q <= d;
        end
    end

    assign axi_o.awready = awready;
    assign axi_o.wready = wready;
    assign axi_o.bvalid = q.bvalid;
    assign axi_o.bresp = q.bresp;
    assign axi_o.arready = arready;
    assign axi_o.rvalid = q.rvalid;
    assign axi_o.rdata = q.rdata;
    assign axi_o.rresp = q.rresp;
    assign cpu_halt = (q.mode != MODE_RUN);
    assign cpu_reset_hold = init_now;
    assign osc_enable = (q.mode != MODE_HW_STANDBY_PIN) && (q.mode != MODE_HW);
    assign clock_supply = clk_on || (q.mode == MODE_RES);
    assign hw_standby_mode = (q.mode == MODE_HW);
    assign int_exc_start = q.int_go;
    assign reset_exc_start = q.res_go;
    assign bus_oe_n = (q.mode == MODE_HW) || (!q.ohe
        && (q.mode == MODE_HW_STANDBY_PIN || q.mode == MODE_OSC));
    assign periph_run = ~q.stop_eff & STOP_GATE_MASK & {16{clk_on}};
    assign periph_access_block = q.stop_eff & STOP_GATE_MASK;
    // serial and converter state is dropped when clocks stop
    assign periph_state_clear = LOST_STATE_MASK
        & (q.stop_eff | {16{off_like}});

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_sleep_entry: assert property (
        (q.mode == MODE_RUN && sleep_exec && !q.standby_select && res_s && hw_s)
        |=> (q.mode == MODE_SLEEP && cpu_halt && periph_run == (~q.stop_eff
        & STOP_GATE_MASK))) else $error("sleep entry wrong");
    a_sleep_stays: assert property (
        (q.mode == MODE_SLEEP && !sleep_wake && res_s && hw_s)
        |=> q.mode == MODE_SLEEP) else $error("sleep left early");
    a_sleep_wake: assert property (
        (q.mode == MODE_SLEEP && sleep_wake && res_s && hw_s)
        |=> (q.mode == MODE_RUN && int_exc_start) ##1 !int_exc_start)
        else $error("sleep wake wrong");
    a_hw_standby: assert property (
        ((q.mode == MODE_SLEEP || q.mode == MODE_HW_STANDBY_PIN) && !hw_s)
        |=> hw_standby_mode && bus_oe_n) else $error("no hw standby");
    a_stop_follow: assert property (
        (bus_cycle_end && !init_now) |=> q.stop_eff == $past(q.stop))
        else $error("stop not applied at cycle end");
    a_stop_hold: assert property (
        (!bus_cycle_end && !init_now) |=> $stable(q.stop_eff))
        else $error("stop changed mid cycle");
    a_block_access: assert property (
        (periph_run & periph_access_block) == '0 && (periph_access_block
        & ~STOP_GATE_MASK) == '0) else $error("stopped module open");
    a_reset_value: assert property (
        $past(!aresetn) |-> (q.stop == STOP_RESET && q.ohe && q.wsel ==
        WSEL_RESET)) else $error("bad reset value");
    a_dma_refuse: assert property (
        (wr_stop && q.wstrb[1] && dma_active && !q.stop[STOP_DMA_BIT]
        && !init_now) |=> !q.stop[STOP_DMA_BIT])
        else $error("dma stop taken while active");
    a_standby_entry: assert property (
        (q.mode == MODE_RUN && sleep_exec && q.standby_select && res_s && hw_s)
        |=> (!osc_enable && !clock_supply && periph_run == '0))
        else $error("standby entry wrong");
    a_irq_ignored: assert property (
        (q.mode == MODE_HW_STANDBY_PIN && !nmi_ev && irq_ok == '0 && res_s && hw_s)
        |=> q.mode == MODE_HW_STANDBY_PIN) else $error("ignored irq woke");
    a_osc_release: assert property (
        (q.mode == MODE_OSC && wake_done && res_s && hw_s)
        |=> (clock_supply && int_exc_start && !cpu_halt))
        else $error("release after count wrong");
    a_res_clocks: assert property (
        (q.mode == MODE_HW_STANDBY_PIN && !res_s && hw_s) |=> (clock_supply
        && osc_enable && cpu_reset_hold)) else $error("reset pin clocks");
endmodule // low_power_mode_controller

// file: rtl/lpm_pkg.sv
package lpm_pkg;

    localparam int unsigned AXI_AW = 8;
    localparam int unsigned WAKE_W = 20;

    // byte addresses of the register words
    localparam logic [AXI_AW-1:0] ADDR_HW_STANDBY_PIN_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] ADDR_MOD_STOP = 8'h04;
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h08;

    // standby_control_reg fields
    localparam int unsigned STANDBY_SELECT_BIT = 7;
    localparam int unsigned WSEL_LSB = 4;
    localparam int unsigned WSEL_MSB = 6;
    localparam int unsigned OHE_BIT = 3;
    localparam int unsigned RSV0_BIT = 0;
    localparam logic STANDBY_SELECT_RESET = 1'h0;
    localparam logic [2:0] WSEL_RESET = 3'h0;
    localparam logic OHE_RESET = 1'h1;
    localparam logic RSV0_RESET = 1'h0;

    // module_stop_reg layout
    localparam logic [15:0] STOP_RESET = 16'h3FFF;
    localparam logic [15:0] STOP_GATE_MASK = 16'hFEE0;
    localparam logic [15:0] LOST_STATE_MASK = 16'h02E0;
    localparam int unsigned STOP_DMA_BIT = 15;
    localparam int unsigned STOP_XFER_BIT = 14;

    // status word fields
    localparam int unsigned STAT_SLEEP_BIT = 0;
    localparam int unsigned STAT_HW_STANDBY_PIN_BIT = 1;
    localparam int unsigned STAT_OSC_BIT = 2;
    localparam int unsigned STAT_EFF_LSB = 16;

    // wake-up count selection
    localparam int unsigned WAKE_BASE_DEFAULT = 8192;
    localparam logic [WAKE_W-1:0] WAKE_SHORT = 20'h00010;
    localparam logic [2:0] WSEL_SHORT = 3'h7;
    localparam logic [2:0] WSEL_RSV = 3'h6;
    localparam logic [2:0] WAKE_RSV_SHIFT = 3'h5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_RUN, MODE_SLEEP, MODE_HW_STANDBY_PIN, MODE_OSC, MODE_RES, MODE_HW
    } mode_t;

    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    // reserved code falls back to the longest wait, the safe side
    function automatic logic [WAKE_W-1:0] wake_count(
        input logic [2:0] sel, input int unsigned base);
        logic [WAKE_W-1:0] b;
        b = WAKE_W'(base);
        if (sel == WSEL_SHORT) begin
            return WAKE_SHORT;
        end else if (sel == WSEL_RSV) begin
            return b << WAKE_RSV_SHIFT;
        end
        return b << sel;
    endfunction

endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync import lpm_pkg::*; #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_t;

    sync_t q, d;

    always_comb begin
        d.s1 = pin_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= {RESET_VAL, RESET_VAL};
        end else begin
            q <= d;
        end
    end

    assign pin_sync_out = q.s2;
endmodule // pin_sync

// file: rtl/wake_counter.sv
`timescale 1ns/100ps
module wake_counter import lpm_pkg::*; #(
    parameter int unsigned WAKE_BASE = WAKE_BASE_DEFAULT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    input wire logic [2:0] sel,
    output logic done
);
    typedef struct packed {
        logic [WAKE_W-1:0] cnt;
    } wcnt_t;

    wcnt_t q, d;
    logic [WAKE_W-1:0] target;

    assign target = wake_count(sel, WAKE_BASE);
    // counts from the first oscillator-settling wait cycle
    assign done = run && (q.cnt == target - 1'h1);

    always_comb begin
        d = q;
        d.cnt = run ? q.cnt + 1'h1 : '0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    a_short_count: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && q.cnt == '0 && sel == WSEL_SHORT) ##1 run [*8] ##1 run [*7]
        |-> done) else $error("short wake count not released");
    a_not_early: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && q.cnt == '0) |-> !done [*2])
        else $error("wake released too early");
endmodule // wake_counter

// file: tb/cpu_bus_model.sv
`timescale 1ns/100ps
module cpu_bus_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // stretch the current bus cycle
    input wire logic pause,
    // end of bus cycle strobe
    output logic bus_cycle_end
);
    logic [1:0] cnt_q;

    // three clocks a cycle; pause stands in for a long wait-state access
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 2'h0;
            bus_cycle_end <= 1'h0;
        end else if (pause) begin
            bus_cycle_end <= 1'h0;
        end else begin
            cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
            bus_cycle_end <= (cnt_q == 2'h2);
        end
    end
endmodule // cpu_bus_model

// file: tb/low_power_mode_controller_test.sv
`timescale 1ns/100ps
module low_power_mode_controller_test import lpm_pkg::*;;
    localparam int WB = 4;
    logic aclk, aresetn, pause, sleep_exec, int_pending, int_disabled;
    logic nonnmi_masked, nmi_edge_select, higher_prio_pending;
    logic dma_active, xfer_active, bus_cycle_end;
    logic nmi_pin, reset_pin_n, hw_standby_pin_n;
    logic [2:0] irq_enable, irq_cpu_masked, irq_xfer_source, irq_pin_n, s;
    logic cpu_halt, cpu_reset_hold, osc_enable, clock_supply;
    logic hw_standby_mode, int_exc_start, reset_exc_start, bus_oe_n;
    logic [15:0] periph_run, periph_access_block, periph_state_clear;
    axil_req_t axi_i;
    axil_rsp_t axi_o;
    int errors, cmp_count, cyc, n;

    low_power_mode_controller #(.WAKE_BASE(WB)) u_low_power_mode_controller (
        .aclk, .aresetn, .axi_i, .axi_o, .sleep_exec, .int_pending,
        .int_disabled, .nonnmi_masked, .nmi_edge_select, .irq_enable,
        .irq_cpu_masked, .irq_xfer_source, .higher_prio_pending,
        .dma_active, .xfer_active, .bus_cycle_end, .nmi_pin, .irq_pin_n,
        .reset_pin_n, .hw_standby_pin_n, .cpu_halt, .cpu_reset_hold,
        .osc_enable, .clock_supply, .hw_standby_mode, .int_exc_start,
        .reset_exc_start, .bus_oe_n, .periph_run, .periph_access_block,
        .periph_state_clear);

    cpu_bus_model u_cpu_bus_model (.aclk, .aresetn, .pause, .bus_cycle_end);

    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("CHECK FAILED t=%0t timeout", $time);
            finish_test();
        end
    end

    function automatic logic pick(input int i);
        case (i)
            0: return cpu_halt;
            1: return osc_enable;
            default: return hw_standby_mode;
        endcase
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        int k;
        k = 0;
        @(posedge aclk);
        axi_i.awvalid <= 1'h1;
        axi_i.awaddr <= a;
        axi_i.wvalid <= 1'h1;
        axi_i.wdata <= d;
        axi_i.wstrb <= 4'hF;
        axi_i.bready <= 1'h1;
        do begin
            @(posedge aclk);
            k++;
            if (axi_o.awready === 1'h1) axi_i.awvalid <= 1'h0;
            if (axi_o.wready === 1'h1) axi_i.wvalid <= 1'h0;
        end while (axi_o.bvalid !== 1'h1 && k < 100);
        axi_i.bready <= 1'h0;
        chk(32'(axi_o.bvalid), 32'h1);
        chk(32'(axi_o.bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        int k;
        k = 0;
        @(posedge aclk);
        axi_i.arvalid <= 1'h1;
        axi_i.araddr <= a;
        axi_i.rready <= 1'h1;
        do begin
            @(posedge aclk);
            k++;
            if (axi_o.arready === 1'h1) axi_i.arvalid <= 1'h0;
        end while (axi_o.rvalid !== 1'h1 && k < 100);
        axi_i.rready <= 1'h0;
        chk(32'(axi_o.rvalid), 32'h1);
        chk(axi_o.rdata, ed);
        chk(32'(axi_o.rresp), 32'(er));
    endtask

    task automatic wfor(input int i, input logic v, output int c);
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (pick(i) !== v && c < 2000);
        chk(32'(pick(i)), 32'(v));
    endtask

    task automatic slp();
        @(posedge aclk);
        sleep_exec <= 1'h1;
        @(posedge aclk);
        sleep_exec <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic finish_test();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        {axi_i, sleep_exec, int_pending, int_disabled, nonnmi_masked} = '0;
        {nmi_edge_select, higher_prio_pending, dma_active, xfer_active} = '0;
        {irq_enable, irq_cpu_masked, irq_xfer_source, pause, aresetn} = '0;
        {errors, cmp_count, cyc} = '0;
        irq_pin_n = 3'h7;
        {nmi_pin, reset_pin_n, hw_standby_pin_n} = 3'h7;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(ADDR_HW_STANDBY_PIN_CTRL, 32'h08, RESP_OKAY);
        rd(ADDR_MOD_STOP, 32'h3FFF, RESP_OKAY);
        rd(ADDR_STATUS, 32'h3FFF0000, RESP_OKAY);
        chk(32'(periph_run), 32'hC000);
        chk(32'(periph_access_block), 32'h3EE0);
        chk(32'(periph_state_clear), 32'h02E0);
        wr(ADDR_HW_STANDBY_PIN_CTRL, 32'hFF, RESP_OKAY);
        rd(ADDR_HW_STANDBY_PIN_CTRL, 32'hF9, RESP_OKAY);
        // the bench is the only writer of the stop register
        pause <= 1'h1;
        wr(ADDR_MOD_STOP, 32'h0, RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(32'(periph_run), 32'hC000);
        pause <= 1'h0;
        repeat (8) @(posedge aclk);
        chk(32'(periph_run), 32'hFEE0);
        chk(32'(periph_access_block), 32'h0);
        wr(ADDR_MOD_STOP, 32'h011F, RESP_OKAY);
        repeat (8) @(posedge aclk);
        chk(32'(periph_run), 32'hFEE0);
        rd(ADDR_MOD_STOP, 32'h011F, RESP_OKAY);
        // no module interrupt is pending when it is stopped
        pause <= 1'h1;
        wr(ADDR_MOD_STOP, 32'h2200, RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(32'(periph_run), 32'hFEE0);
        pause <= 1'h0;
        repeat (8) @(posedge aclk);
        chk(32'(periph_run), 32'hDCE0);
        chk(32'(periph_access_block), 32'h2200);
        chk(32'(periph_state_clear), 32'h0200);
        dma_active <= 1'h1;
        wr(ADDR_MOD_STOP, 32'hC000, RESP_OKAY);
        rd(ADDR_MOD_STOP, 32'h4000, RESP_OKAY);
        dma_active <= 1'h0;
        xfer_active <= 1'h1;
        wr(ADDR_MOD_STOP, 32'h0, RESP_OKAY);
        wr(ADDR_MOD_STOP, 32'hC000, RESP_OKAY);
        rd(ADDR_MOD_STOP, 32'h8000, RESP_OKAY);
        xfer_active <= 1'h0;
        wr(ADDR_MOD_STOP, 32'h0, RESP_OKAY); // never all ones
        rd(8'h0C, 32'h0, RESP_SLVERR);
        wr(8'h10, 32'h1, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h0, RESP_OKAY);
        // sleep: wakes only once interrupts may be taken
        wr(ADDR_HW_STANDBY_PIN_CTRL, 32'h08, RESP_OKAY);
        int_pending <= 1'h1;
        int_disabled <= 1'h1;
        slp();
        chk(32'(clock_supply), 32'h1);
        chk(32'(periph_run), 32'hFEE0);
        rd(ADDR_STATUS, 32'h1, RESP_OKAY);
        int_disabled <= 1'h0;
        nonnmi_masked <= 1'h1;
        repeat (10) @(posedge aclk);
        chk(32'(cpu_halt), 32'h1);
        nonnmi_masked <= 1'h0;
        wfor(0, 1'h0, n);
        chk(32'(int_exc_start), 32'h1);
        int_pending <= 1'h0;
        // every wake delay code, woken by alternating nmi edges
        // external clock, so every code may be used
        // no write buffer to drain before standby
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            nmi_edge_select <= ~nmi_pin;
            wr(ADDR_HW_STANDBY_PIN_CTRL, 32'h80 | 32'(s) << 4 | 32'(s[0]) << 3,
                RESP_OKAY);
            slp();
            chk(32'(osc_enable | clock_supply), 32'h0);
            chk(32'(bus_oe_n), 32'(!s[0]));
            chk(32'(periph_state_clear), 32'h02E0);
            nmi_pin <= ~nmi_pin;
            wfor(1, 1'h1, n);
            wfor(0, 1'h0, n);
            chk(n, s == 7 ? 16 : WB << (s == 6 ? 5 : s));
            chk(32'(int_exc_start), 32'h1);
        end
        rd(ADDR_MOD_STOP, 32'h0, RESP_OKAY);
        // irq wake held off while masked or owned by the transfer unit
        wr(ADDR_HW_STANDBY_PIN_CTRL, 32'hF0, RESP_OKAY);
        irq_enable <= 3'h1;
        irq_cpu_masked <= 3'h1;
        irq_pin_n <= 3'h6;
        slp();
        repeat (20) @(posedge aclk);
        chk(32'(osc_enable), 32'h0);
        irq_cpu_masked <= 3'h0;
        irq_xfer_source <= 3'h1;
        repeat (20) @(posedge aclk);
        chk(32'(osc_enable), 32'h0);
        irq_xfer_source <= 3'h0;
        higher_prio_pending <= 1'h1;
        repeat (20) @(posedge aclk);
        chk(32'(osc_enable), 32'h0);
        higher_prio_pending <= 1'h0;
        wfor(0, 1'h0, n);
        chk(32'(int_exc_start), 32'h1);
        irq_pin_n <= 3'h7;
        irq_enable <= 3'h0;
        slp();
        reset_pin_n <= 1'h0;
        repeat (6) @(posedge aclk);
        chk(32'({clock_supply, osc_enable, cpu_reset_hold}), 32'h7);
        reset_pin_n <= 1'h1;
        wfor(0, 1'h0, n);
        chk(32'(reset_exc_start), 32'h1);
        wr(ADDR_MOD_STOP, 32'h1234, RESP_OKAY);
        slp();
        hw_standby_pin_n <= 1'h0;
        wfor(2, 1'h1, n);
        chk(32'({hw_standby_mode, osc_enable, bus_oe_n}), 32'h5);
        hw_standby_pin_n <= 1'h1;
        wfor(0, 1'h0, n);
        rd(ADDR_MOD_STOP, 32'h3FFF, RESP_OKAY);
        finish_test();
    end
endmodule // low_power_mode_controller_test
